// >>> core/pfm_pkg.sv
// Purpose: Constants shared by the pin function multiplexer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Pin, function and code widths are fixed here.
package pfm_pkg;
  localparam int NUM_PINS = 16;
  localparam int NUM_RIN = 8;
  localparam int NUM_ROUT = 8;
  localparam int SEL_W = 4;
  localparam int ROUT_W = 4;
  // Remap output code 0 means no remappable output on the pin.
  localparam logic [ROUT_W-1:0] ROUT_NONE = 4'h0;
  localparam logic [NUM_PINS-1:0] ANALOG_RST = 16'hFFFF;
  localparam logic [NUM_PINS-1:0] DIR_RST = 16'hFFFF;
  localparam logic [NUM_PINS-1:0] ZERO_PINS = 16'h0000;
  // Remappable input index 0 is the second serial port data in,
  // index 1 its clock in, index 2 its select in, index 3 PWM fault.
  localparam int RIN_SSP_DI = 0;
  localparam int RIN_SSP_CK = 1;
  localparam int RIN_SSP_SS = 2;
  localparam int RIN_PWM_FLT = 3;
  // Fixed pin of external interrupt zero.
  localparam int EXT_EXTERNAL_INTERRUPT_ZERO_PIN = 0;
endpackage

// >>> core/pfm_pin_function_mux.sv
// Purpose: Per-pin function ownership, analog default and pull control.
// Assumes: Pin inputs are synchronous to sys_clk.
// Notes: Priority order is dedicated output, remap output, port; analog gates inputs only.
// Summary of operation
// R01: After reset every pin sharing an analog input starts as analog.
// R02: Analog pins disable digital input; port and latch reads return zero.
// R03: Software clears the analog select bit to use a pin digitally.
// R04: Direction control may still enable the output driver on analog pins.
// R05: Highest priority enabled function owns the pin; lower ones inactive.
// R06: Every pin has individually enabled weak pull-up and pull-down.
// R07: At most one output function drives a pin at any time.
// R08: One remappable output may be routed to several pins at once.
// R09: A dedicated output overrides a remappable output on the same pin.
// R10: Remappable inputs still read pins used by dedicated digital functions.
// R11: Dedicated analog disables digital inputs but allows one output.
// R12: Many remappable inputs may read the same pin, even a driven one.
// R13: External interrupt zero is fixed to its own pin, not remappable.
// R14: Only the second serial peripheral port is remappable.
// R15: Of the PWM signals only the fault inputs are remappable.
// R16: Ownership is resolved combinationally from current settings.
module pfm_pin_function_mux (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration writes
  input wire logic cfgWe,
  input wire logic [pfm_pkg::NUM_PINS-1:0] analogSelectIn,
  input wire logic [pfm_pkg::NUM_PINS-1:0] directionControlIn,
  input wire logic [pfm_pkg::NUM_PINS-1:0] outputLatchIn,
  input wire logic [pfm_pkg::NUM_PINS-1:0] pullUpEnableIn,
  input wire logic [pfm_pkg::NUM_PINS-1:0] pullDownEnableIn,
  // Remap selection
  input wire logic remapWe,
  input wire logic [pfm_pkg::ROUT_W-1:0] remapOutSelIn [pfm_pkg::NUM_PINS],
  input wire logic [pfm_pkg::SEL_W-1:0] remapInSelIn [pfm_pkg::NUM_RIN],
  // Peripheral outputs
  input wire logic [pfm_pkg::NUM_PINS-1:0] dedOutEn,
  input wire logic [pfm_pkg::NUM_PINS-1:0] dedOutVal,
  input wire logic [pfm_pkg::NUM_ROUT-1:0] remapOutVal,
  // Package pins
  input wire logic [pfm_pkg::NUM_PINS-1:0] pinIn,
  output logic [pfm_pkg::NUM_PINS-1:0] pinOut,
  output logic [pfm_pkg::NUM_PINS-1:0] pinOe,
  output logic [pfm_pkg::NUM_PINS-1:0] pullUpOn,
  output logic [pfm_pkg::NUM_PINS-1:0] pullDownOn,
  // Readback and peripheral inputs
  output logic [pfm_pkg::NUM_PINS-1:0] analogSelect,
  output logic [pfm_pkg::NUM_PINS-1:0] portInputValue,
  output logic [pfm_pkg::NUM_PINS-1:0] outputLatchRead,
  output logic [pfm_pkg::NUM_PINS-1:0] dedInVal,
  output logic [pfm_pkg::NUM_RIN-1:0] remapInVal,
  output logic externalInterruptZero
);
  localparam int NP = pfm_pkg::NUM_PINS;
  localparam int NI = pfm_pkg::NUM_RIN;

  logic [NP-1:0] analogQ;
  logic [NP-1:0] dirQ;
  logic [NP-1:0] latQ;
  logic [NP-1:0] puQ;
  logic [NP-1:0] pdQ;
  logic [pfm_pkg::ROUT_W-1:0] outSelQ [NP];
  logic [pfm_pkg::SEL_W-1:0] inSelQ [NI];
  logic [NP-1:0] outD;
  logic [NP-1:0] oeD;
  logic [NP-1:0] digInD;
  logic [NI-1:0] rinD;
  // Per-pin ownership flags; at most one of them is high on any pin.
  logic [NP-1:0] ownDed;
  logic [NP-1:0] ownRemap;
  logic [NP-1:0] ownPort;
  logic [NP-1:0] remapCodeOk;

  // Analog select resets to all analog; software clears bits to go digital.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      analogQ <= pfm_pkg::ANALOG_RST; // R01
    end else if (cfgWe) begin
      analogQ <= analogSelectIn; // R03
    end
  end

  // Direction resets to input on every pin.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dirQ <= pfm_pkg::DIR_RST;
    end else if (cfgWe) begin
      dirQ <= directionControlIn;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latQ <= pfm_pkg::ZERO_PINS;
    end else if (cfgWe) begin
      latQ <= outputLatchIn;
    end
  end

  // Pull-up and pull-down are enabled each by its own bit per pin.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      puQ <= pfm_pkg::ZERO_PINS;
    end else if (cfgWe) begin
      puQ <= pullUpEnableIn; // R06
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pdQ <= pfm_pkg::ZERO_PINS;
    end else if (cfgWe) begin
      pdQ <= pullDownEnableIn; // R06
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NP; i++) begin
        outSelQ[i] <= pfm_pkg::ROUT_NONE;
      end
      for (int j = 0; j < NI; j++) begin
        inSelQ[j] <= '0;
      end
    end else if (remapWe) begin
      for (int i = 0; i < NP; i++) begin
        outSelQ[i] <= remapOutSelIn[i]; // R08
      end
      for (int j = 0; j < NI; j++) begin
        inSelQ[j] <= remapInSelIn[j];
      end
    end
  end

  // Each pin picks at most one output source by priority.
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : gPin
      // Codes above the function count select nothing, so no X reaches
      // the pin from an index beyond the remap output vector.
      assign remapCodeOk[g] = (outSelQ[g] != pfm_pkg::ROUT_NONE) &&
        (outSelQ[g] <= pfm_pkg::ROUT_W'(pfm_pkg::NUM_ROUT));
      assign ownDed[g] = dedOutEn[g]; // R09
      assign ownRemap[g] = ~dedOutEn[g] & remapCodeOk[g]; // R08
      assign ownPort[g] = ~dedOutEn[g] & ~remapCodeOk[g] & ~dirQ[g]; // R04
      always_comb begin // R16
        outD[g] = 1'b0;
        if (ownDed[g]) begin // R05
          outD[g] = dedOutVal[g];
        end else if (ownRemap[g]) begin
          outD[g] = remapOutVal[3'(outSelQ[g] - 4'h1)];
        end else if (ownPort[g]) begin
          outD[g] = latQ[g];
        end
      end
      assign oeD[g] = ownDed[g] | ownRemap[g] | ownPort[g]; // R07
      // Analog pins keep a single output but no digital input.
      assign digInD[g] = pinIn[g] & ~analogQ[g]; // R02 R11
    end
  endgenerate

  // Remappable inputs read any digital pin, shared freely.
  always_comb begin // R10 R12
    rinD = '0;
    for (int j = 0; j < NI; j++) begin
      rinD[j] = digInD[inSelQ[j]];
    end
  end

  // Pin drive registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinOut <= '0;
      pinOe <= '0;
    end else begin
      pinOut <= outD;
      pinOe <= oeD; // R07
    end
  end

  // Pull control registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pullUpOn <= '0;
      pullDownOn <= '0;
    end else begin
      pullUpOn <= puQ; // R06
      pullDownOn <= pdQ; // R06
    end
  end

  // Readback registers; port and latch reads of analog pins are zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      analogSelect <= pfm_pkg::ANALOG_RST;
      portInputValue <= '0;
      outputLatchRead <= '0;
    end else begin
      analogSelect <= analogQ;
      portInputValue <= digInD; // R02
      outputLatchRead <= latQ & ~analogQ; // R02
    end
  end

  // Peripheral input registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dedInVal <= '0;
      remapInVal <= '0;
      externalInterruptZero <= 1'b0;
    end else begin
      dedInVal <= digInD; // R11
      // Only second serial port and PWM fault inputs are remap routed.
      remapInVal <= rinD; // R14 R15
      externalInterruptZero <= digInD[pfm_pkg::EXT_EXTERNAL_INTERRUPT_ZERO_PIN]; // R13
    end
  end
endmodule

// >>> sim/pfm_pin_function_mux_monitor.sv
// Purpose: Port checks. Assumes: Writes land in two edges. Notes: Bound.
module pfm_pin_function_mux_monitor (
  input wire logic sys_clk, rst, cfgWe, externalInterruptZero,
  input wire logic [15:0] pinIn, pinOut, pinOe, dedOutEn, dedOutVal,
  input wire logic [15:0] analogSelect, portInputValue, outputLatchRead,
  input wire logic [15:0] outputLatchIn, directionControlIn, pullUpOn,
  input wire logic [15:0] pullUpEnableIn
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  AST_RST: assert property ($past(rst) |-> &analogSelect)
    else $error("rst");
  AST_PORT: assert property (portInputValue ==
    ($past(pinIn) & ~analogSelect)) else $error("port");
  AST_EXTERNAL_INTERRUPT_ZERO: assert property (externalInterruptZero ==
    ($past(pinIn[0]) & ~analogSelect[0])) else $error("external_interrupt_zero");
  AST_LAT: assert property (cfgWe |-> ##2 outputLatchRead ==
    ($past(outputLatchIn, 2) & ~analogSelect)) else $error("latch");
  AST_PULL: assert property (cfgWe |-> ##2
    pullUpOn == $past(pullUpEnableIn, 2)) else $error("pull");
  AST_DIR: assert property (cfgWe |-> ##2
    &(pinOe | $past(directionControlIn, 2))) else $error("dir");
  AST_DOE: assert property (!$past(rst) |->
    &(pinOe | ~$past(dedOutEn))) else $error("ded oe");
  AST_DVAL: assert property (!$past(rst) |->
    ((pinOut ^ $past(dedOutVal)) & $past(dedOutEn)) == 0) else $error("ded");
  cover property (cfgWe && !directionControlIn);
  cover property (dedOutEn && pinOe);
  cover property (!analogSelect);
endmodule
bind pfm_pin_function_mux pfm_pin_function_mux_monitor u_mon (.*);

// >>> sim/pfm_pad_model.sv
// Purpose: Pads. Assumes: Idle pads show boardVal. Notes: Up beats down.
module pfm_pad_model (
  input wire logic [15:0] pinOut, pinOe, pullUpOn, pullDownOn, boardVal,
  output logic [15:0] pinIn
);
  assign pinIn = pinOe & pinOut |
    ~pinOe & (pullUpOn | ~pullDownOn & boardVal);
endmodule

// >>> sim/pfm_pin_function_mux_tb.sv
// Purpose: Directed tests. Assumes: Pads close the loop. Notes: None.
module pfm_pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, cfgWe = 0, remapWe = 0, externalInterruptZero;
  logic [15:0] analogSelectIn = 0, directionControlIn = 0, outputLatchIn = 0;
  logic [15:0] pullUpEnableIn = 0, pullDownEnableIn = 0, pinIn, pinOut;
  logic [15:0] pinOe, pullUpOn, pullDownOn, analogSelect, portInputValue;
  logic [15:0] outputLatchRead, dedInVal, dedOutEn = 0, dedOutVal = 0;
  logic [15:0] boardVal = 16'hFFFF;
  logic [7:0] remapOutVal = 0, remapInVal;
  logic [3:0] remapOutSelIn [16] = '{default: 4'h0};
  logic [3:0] remapInSelIn [8] = '{default: 4'h0};
  int failures = 0, checked = 0;
  pfm_pin_function_mux u_dut (.*);
  pfm_pad_model u_pad (.*);
  initial forever #2 sys_clk = ~sys_clk;
  task automatic chk(input logic [63:0] got, exp);
    checked++;
    if (got !== exp) failures++;
    if (got !== exp) $display("wrong value at %0t: %h", $time, got);
  endtask
  task automatic cfg(input logic [79:0] v);
    {analogSelectIn, directionControlIn, outputLatchIn} = v[79:32];
    {pullUpEnableIn, pullDownEnableIn, cfgWe, remapWe} = {v[31:0], 2'b11};
    @(negedge sys_clk);
    {cfgWe, remapWe} = 2'b00;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("%0d checked %0d failed", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 0;
    @(negedge sys_clk);
    chk({analogSelect, portInputValue}, 32'hFFFF0000);
    cfg({16'hFFFF, 16'hFF00, 16'h00A5, 32'h0});
    chk({pinOe, pinOut & pinOe}, 32'h00FF00A5);
    chk({outputLatchRead, dedInVal}, 32'h0);
    cfg({16'hF000, 16'hFFFF, 16'h1234, 16'h00FF, 16'h0F00});
    chk({portInputValue, outputLatchRead}, 32'h00FF0234);
    chk({pullUpOn, pullDownOn, dedInVal}, 48'h00FF0F0000FF);
    chk(externalInterruptZero, 64'h1);
    {dedOutEn, dedOutVal} = {2{16'h0020}};
    for (int i = 4; i < 7; i++) remapOutSelIn[i] = 4'h1;
    remapOutSelIn[7] = 4'h9;
    foreach (remapInSelIn[i]) remapInSelIn[i] = i < 4 ? 4'h4 : 4'h5;
    cfg({32'h0, 16'hFFFF, 32'h0});
    chk({pinOut, pinOe, remapInVal}, 40'hFFAFFFFFF0);
    remapOutVal = 8'h01;
    repeat (4) @(negedge sys_clk);
    chk({pinOut, remapInVal}, 24'hFFFFFF);
    tally_and_finish();
  end
endmodule
